// [testbench/asu_peer.sv]
/* asu_peer: serial device on one channel, sends frames and captures bytes.
   assumes 8 data bits on capture; bit period given in clock cycles. */
module asu_peer (
  input wire logic aclk, // clock
  input wire logic txd, // line from core
  output logic rxd // line to core
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rxd = 1'b1;
  // n of 0 gives a lone one-cycle pulse when bp is 1
  task automatic send(input logic [11:0] f, input int n, input int bp);
    rxd <= 1'b0;
    repeat (bp) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      rxd <= f[i];
      repeat (bp) @(posedge aclk);
    end
    rxd <= 1'b1;
  endtask
  // samples on falling edges, clear of the core's register updates
  task automatic recv(output logic [7:0] d, input int bp);
    @(negedge txd);
    repeat (bp + bp / 2) @(negedge aclk);
    for (int i = 0; i < 8; i++) begin
      d[i] = txd;
      repeat (bp) @(negedge aclk);
    end
  endtask
endmodule

// [testbench/asu_props.sv]
/* asu_props: port checks on the serial core.
   assumes a bind to asu_uart_core and a divisor of at least one. */
module asu_props
  import asu_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic [NCH-1:0] txd, // serial out
  input wire asu_mdm_out_t [NCH-1:0] mdm_out, // modem out
  input wire logic [NCH-1:0] ir_mode // ir mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a low bit lasts 16 ticks, so at least 9 cycles
  sequence s_low;
    !txd[0] [*8];
  endsequence
  property p_txd_rst; $rose(aresetn) |-> txd == 3'h7; endproperty
  a_txd_rst: assert property (p_txd_rst) else $error("txd not idle after reset");
  property p_mdm_rst; $rose(aresetn) |-> mdm_out == 6'h3F; endproperty
  a_mdm_rst: assert property (p_mdm_rst) else $error("modem out active after reset");
  property p_ir_rst; $rose(aresetn) |-> ir_mode == 3'h4; endproperty
  a_ir_rst: assert property (p_ir_rst) else $error("ir mode wrong after reset");
  property p_ch_pins; mdm_out[2] == 2'h3 && mdm_out[1].dtr_n; endproperty
  a_ch_pins: assert property (p_ch_pins) else $error("missing modem line driven");
  property p_bit_len; $fell(txd[0]) |=> s_low; endproperty
  a_bit_len: assert property (p_bit_len) else $error("low bit too short");
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_done: assert property (p_r_done) else $error("rvalid held after handshake");
  property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_done: assert property (p_b_done) else $error("bvalid held after handshake");
  property p_r_high; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_r_high: assert property (p_r_high) else $error("read data upper bits set");
endmodule

bind asu_uart_core asu_props i_props (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .txd, .mdm_out, .ir_mode);

// [testbench/tb_top.sv]
/* tb_top: register and serial tests of the three channel serial core.
   assumes asu_peer on channel 0 and the checker bound to the core. */
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; $display("MISMATCH %0t %h vs %h", $time, g, e); end end
module tb_top
  import asu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  wire [NCH-1:0] rxd;
  logic [NCH-1:0] txd, ir_mode, irq;
  asu_mdm_in_t [NCH-1:0] mdm_in = '1;
  asu_mdm_out_t [NCH-1:0] mdm_out;
  int fails = 0, checked = 0;
  logic [31:0] rv;
  logic [7:0] got;
  logic [19:0] rst_tab [7] = '{20'h00400, 20'h00801, 20'h00C00, 20'h01000, 20'h01460, 20'h40801, 20'h82001};
  logic [11:0] ef [3] = '{12'h33C, 12'h03C, 12'h000};
  logic [7:0] em [3] = '{8'h04, 8'h08, 8'h10};
  always #2.5 aclk = ~aclk;
  assign rxd[2:1] = 2'h3;
  asu_uart_core i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd, .txd, .mdm_in, .mdm_out,
    .ir_mode, .irq);
  asu_peer i_peer (.aclk, .txd(txd[0]), .rxd(rxd[0]));
  // ready is sampled on the falling edge: it only moves after rising edges
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OK);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
      @(posedge aclk);
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    `CHK(s_axi_bresp, r)
    @(posedge aclk);
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF,
                    input logic [1:0] r = RESP_OK);
    logic p;
    p = 1'b1;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (p) begin
      @(negedge aclk);
      p = !s_axi_arready;
      @(posedge aclk);
      s_axi_arvalid <= p;
    end
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    `CHK(s_axi_rresp, r)
    `CHK(rv[7:0] & m, e)
    @(posedge aclk);
  endtask
  task automatic wrap_up();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100us;
    fails++;
    $display("MISMATCH %0t watchdog", $time);
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    `CHK(ir_mode, 3'h4)
    foreach (rst_tab[i]) rc(rst_tab[i][19:8], rst_tab[i][7:0]);
    rc(12'h024, 8'h00, 8'hFF, RESP_ERR);
    wr(12'hC00, 8'h00, RESP_ERR);
    wr(12'h820, 8'h00);
    `CHK(ir_mode, 3'h0)
    wr(12'h010, 8'h03);
    wr(12'h410, 8'h03);
    `CHK(mdm_out[0], 2'h0)
    `CHK(mdm_out[1], 2'h2)
    wr(12'h004, 8'h08);
    mdm_in[0].cts_n <= 1'b0;
    repeat (4) @(posedge aclk);
    `CHK(irq[0], 1'b1)
    rc(12'h008, IID_MS);
    rc(12'h018, 8'h11);
    mdm_in[0].ri_n <= 1'b0;
    repeat (4) @(posedge aclk);
    rc(12'h018, 8'h50);
    mdm_in[0].ri_n <= 1'b1;
    repeat (4) @(posedge aclk);
    rc(12'h018, 8'h14);
    rc(12'h008, IID_NONE);
    wr(12'h004, 8'h02);
    rc(12'h008, IID_TH);
    rc(12'h008, IID_NONE);
    for (int dv = 2; dv > 0; dv--) begin
      wr(12'h00C, 8'h80);
      wr(12'h000, 8'(dv));
      rc(12'h000, 8'(dv));
      rc(12'h004, 8'h00);
      wr(12'h00C, 8'h03);
      fork
        i_peer.recv(got, 16 * dv);
        wr(12'h000, 8'hA5);
      join
      `CHK(got, 8'hA5)
      repeat (40) @(posedge aclk);
    end
    wr(12'h004, 8'h05);
    i_peer.send(12'h000, 0, 1);
    repeat (4) @(posedge aclk);
    i_peer.send(12'h13C, 9, 16);
    repeat (8) @(posedge aclk);
    rc(12'h014, 8'h61);
    rc(12'h008, IID_RD);
    rc(12'h000, 8'h3C);
    rc(12'h014, 8'h60);
    i_peer.send(12'h13C, 9, 16);
    i_peer.send(12'h13C, 9, 16);
    repeat (8) @(posedge aclk);
    rc(12'h014, 8'h02, 8'h02);
    rc(12'h000, 8'h3C);
    for (int k = 0; k < 3; k++) begin
      wr(12'h00C, k == 0 ? 8'h1B : 8'h03);
      i_peer.send(ef[k], k == 0 ? 10 : 9, 16);
      repeat (40) @(posedge aclk);
      rc(12'h008, IID_LS);
      rc(12'h014, em[k], em[k]);
      rc(12'h000, k == 2 ? 8'h00 : 8'h3C);
    end
    wr(12'h00C, 8'h43);
    repeat (20) @(posedge aclk);
    `CHK(txd[0], 1'b0)
    wr(12'h00C, 8'h03);
    wr(12'h010, 8'h10);
    wr(12'h000, 8'h5A);
    repeat (20) @(posedge aclk);
    `CHK(txd[0], 1'b1)
    repeat (200) @(posedge aclk);
    rc(12'h000, 8'h5A);
    wr(12'h010, 8'h1C);
    rc(12'h018, 8'hC0, 8'hF0);
    wr(12'h00C, 8'h2C);
    wr(12'h000, 8'h5A);
    repeat (200) @(posedge aclk);
    rc(12'h014, 8'h01, 8'h1F);
    rc(12'h000, 8'h1A);
    wrap_up();
  end
endmodule

// [verilog/asu_pkg.sv]
/*
  asu_pkg: register offsets, field positions, reset values, counts and types
  shared by the three-channel asynchronous serial core.
  assumes one clock (aclk) and register access over AXI4-Lite.
*/
package asu_pkg;
  localparam int NCH = 3;
  localparam int CH_LSB = 10;
  localparam logic [1:0] CH_NONE = 2'h3;
  localparam logic [1:0] GAP_ZERO = 2'h0;

  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_IE = 8'h04;
  localparam logic [7:0] OFF_IID = 8'h08;
  localparam logic [7:0] OFF_LC = 8'h0C;
  localparam logic [7:0] OFF_MC = 8'h10;
  localparam logic [7:0] OFF_LS = 8'h14;
  localparam logic [7:0] OFF_MS = 8'h18;
  localparam logic [7:0] OFF_SCR = 8'h1C;
  localparam logic [7:0] OFF_IRC = 8'h20;

  localparam int LC_STB = 2;
  localparam int LC_PEN = 3;
  localparam int LC_EPS = 4;
  localparam int LC_STICK = 5;
  localparam int LC_BRK = 6;
  localparam int LC_DIVISOR_ACCESS_SELECT = 7;
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_OUT1 = 2;
  localparam int MC_OUT2 = 3;
  localparam int MC_LOOP = 4;
  localparam int IE_RD = 0;
  localparam int IE_TH = 1;
  localparam int IE_LS = 2;
  localparam int IE_MS = 3;

  localparam logic [7:0] IID_NONE = 8'h01;
  localparam logic [7:0] IID_LS = 8'h06;
  localparam logic [7:0] IID_RD = 8'h04;
  localparam logic [7:0] IID_TH = 8'h02;
  localparam logic [7:0] IID_MS = 8'h00;

  localparam logic [7:0] IE_RST = 8'h00;
  localparam logic [7:0] LC_RST = 8'h00;
  localparam logic [7:0] MC_RST = 8'h00;
  localparam logic [7:0] DLL_RST = 8'h01;
  localparam logic [7:0] DLM_RST = 8'h00;

  localparam logic [3:0] CNT_MID = 4'h7;
  localparam logic [3:0] CNT_LAST = 4'hF;
  localparam logic [4:0] STOP1_LAST = 5'h0F;
  localparam logic [4:0] STOP15_LAST = 5'h17;
  localparam logic [4:0] STOP2_LAST = 5'h1F;
  localparam logic [1:0] FILT_LAST = 2'h1;
  localparam logic [2:0] WLS_BASE = 3'h4;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP, ST_BRK} asu_state_t;

  typedef struct packed {
    logic dcd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } asu_mdm_in_t;

  typedef struct packed {
    logic dtr_n;
    logic rts_n;
  } asu_mdm_out_t;
endpackage

// [verilog/asu_uart_core.sv]
/*
  asu_uart_core: AXI4-Lite slave over three serial channels, and the channel
  itself (baud generator, transmitter, receiver, modem control, interrupt id).
  assumes pins synchronous to aclk; modem pins come from the pin multiplexer.
*/
module asu_uart_core
  import asu_pkg::*;
(
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, low
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [NCH-1:0] rxd, // serial inputs
  output logic [NCH-1:0] txd, // serial outputs
  input wire asu_mdm_in_t [NCH-1:0] mdm_in, // modem inputs, active low
  output asu_mdm_out_t [NCH-1:0] mdm_out, // modem outputs, active low
  output logic [NCH-1:0] ir_mode, // channel in infrared mode
  output logic [NCH-1:0] irq // channel interrupt requests
);
  logic aw_have_reg;
  logic w_have_reg;
  logic [11:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  logic w_lane_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wr_go;
  logic ar_go;
  logic [11:0] acc_addr;
  logic [1:0] sel;
  logic in_range;
  logic [NCH-1:0] ch_hit;
  logic [7:0] ch_rdata [NCH];

  assign wr_go = aw_have_reg && w_have_reg && !bvalid_reg;
  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready = !w_have_reg && !bvalid_reg;
  // a pending write owns the shared decode, so reads wait one cycle
  assign s_axi_arready = !rvalid_reg && !wr_go;
  assign ar_go = s_axi_arvalid && s_axi_arready;
  assign acc_addr = wr_go ? aw_addr_reg : s_axi_araddr;
  assign sel = acc_addr[CH_LSB+1:CH_LSB];
  assign in_range = (acc_addr[CH_LSB-1:CH_LSB-2] == GAP_ZERO) && (sel != CH_NONE);
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'h0;
      aw_addr_reg <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_reg <= 1'h1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_have_reg <= 1'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_reg <= 1'h0;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_reg <= 1'h1;
      w_data_reg <= s_axi_wdata[7:0];
      w_lane_reg <= s_axi_wstrb[0];
    end else if (wr_go) begin
      w_have_reg <= 1'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'h0;
      bresp_reg <= RESP_OK;
    end else if (wr_go) begin
      bvalid_reg <= 1'h1;
      bresp_reg <= (in_range && ch_hit[sel]) ? RESP_OK : RESP_ERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'h0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OK;
    end else if (ar_go) begin
      rvalid_reg <= 1'h1;
      if (in_range && ch_hit[sel]) begin
        rdata_reg <= {24'h00_0000, ch_rdata[sel]};
        rresp_reg <= RESP_OK;
      end else begin
        rdata_reg <= 32'h0000_0000;
        rresp_reg <= RESP_ERR;
      end
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'h0;
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    asu_channel #(.CH(g)) u_ch (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_en(wr_go && w_lane_reg && in_range && (sel == 2'(g))),
      .rd_en(ar_go && in_range && (sel == 2'(g))),
      .addr(acc_addr[7:0]),
      .wdata(w_data_reg),
      .rdata(ch_rdata[g]),
      .hit(ch_hit[g]),
      .rxd(rxd[g]),
      .txd(txd[g]),
      .mdm_in(mdm_in[g]),
      .mdm_out(mdm_out[g]),
      .ir_mode(ir_mode[g]),
      .irq(irq[g])
    );
  end
endmodule

module asu_channel
  import asu_pkg::*;
#(
  parameter int CH = 0
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, low
  input wire logic wr_en, // register write strobe
  input wire logic rd_en, // register read strobe
  input wire logic [7:0] addr, // byte offset
  input wire logic [7:0] wdata, // write data
  output logic [7:0] rdata, // read data
  output logic hit, // offset is mapped
  input wire logic rxd, // serial input
  output logic txd, // serial output
  input wire asu_mdm_in_t mdm_in, // modem inputs
  output asu_mdm_out_t mdm_out, // modem outputs
  output logic ir_mode, // infrared mode
  output logic irq // interrupt request
);
  localparam bit HAS_RC = (CH < 2);
  localparam bit HAS_FULL = (CH == 0);
  localparam logic IR_RST = (CH == 2);

  logic [7:0] ie_reg, lc_reg, mc_reg, scr_reg, dll_reg, dlm_reg, thr_reg, rbr_reg;
  logic ir_reg;
  logic [15:0] bcnt_reg;
  logic btick, divisor_access_select, loop;
  logic [3:0] mst, mst_prev_reg, delta_reg, delta_next;
  logic [4:0] ls_reg;
  logic thr_empty_reg, thre_pend_reg, txd_reg, tx_ser_reg, tx_par_reg;
  logic [7:0] tsr_reg, dmask;
  logic [2:0] tx_bit_reg, rx_bit_reg, last_bit;
  logic [4:0] tx_cnt_reg, stop_last;
  asu_state_t tx_st_reg, rx_st_reg;
  logic tx_load, tx_tick_end;
  logic rx_in, rx_filt_reg, rx_par_reg, rx_fin, rx_pe, rx_fe, rx_bi;
  logic [1:0] filt_cnt_reg;
  logic [3:0] rx_cnt_reg;
  logic [7:0] rsr_reg;
  logic [7:0] iid;
  logic wr_data, wr_ie, rd_data, rd_ls, rd_ms, rd_iid;

  assign divisor_access_select = lc_reg[LC_DIVISOR_ACCESS_SELECT];
  assign loop = mc_reg[MC_LOOP];
  assign wr_data = wr_en && addr == OFF_DATA && !divisor_access_select;
  assign wr_ie = wr_en && addr == OFF_IE && !divisor_access_select;
  assign rd_data = rd_en && addr == OFF_DATA && !divisor_access_select;
  assign rd_ls = rd_en && addr == OFF_LS;
  assign rd_ms = rd_en && addr == OFF_MS;
  assign rd_iid = rd_en && addr == OFF_IID;
  assign last_bit = WLS_BASE + {1'h0, lc_reg[1:0]};
  assign dmask = 8'hFF >> (2'h3 - lc_reg[1:0]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ie_reg <= IE_RST;
      lc_reg <= LC_RST;
      mc_reg <= MC_RST;
      scr_reg <= 8'h00;
      dll_reg <= DLL_RST;
      dlm_reg <= DLM_RST;
      ir_reg <= IR_RST;
    end else if (wr_en) begin
      if (addr == OFF_DATA && divisor_access_select) begin
        dll_reg <= wdata;
      end else if (addr == OFF_IE && divisor_access_select) begin
        dlm_reg <= wdata;
      end else if (addr == OFF_IE) begin
        ie_reg <= {4'h0, wdata[3:0]};
      end else if (addr == OFF_LC) begin
        lc_reg <= wdata;
      end else if (addr == OFF_MC) begin
        mc_reg <= {3'h0, wdata[4:0]};
      end else if (addr == OFF_SCR) begin
        scr_reg <= wdata;
      end else if (addr == OFF_IRC) begin
        ir_reg <= wdata[0];
      end
    end
  end

  // divisor 0 wraps to 16'hFFFF reload, i.e. divide by 65536
  assign btick = (bcnt_reg == 16'h0000);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bcnt_reg <= 16'h0000;
    end else if (btick) begin
      bcnt_reg <= {dlm_reg, dll_reg} - 16'h0001;
    end else begin
      bcnt_reg <= bcnt_reg - 16'h0001;
    end
  end

  // outside loop-back, missing lines read inactive rather than floating pin values
  always_comb begin
    if (loop) begin
      mst = {mc_reg[MC_OUT2], mc_reg[MC_OUT1], mc_reg[MC_DTR], mc_reg[MC_RTS]};
    end else begin
      mst = {HAS_FULL & ~mdm_in.dcd_n, HAS_RC & ~mdm_in.ri_n,
             HAS_FULL & ~mdm_in.dsr_n, HAS_RC & ~mdm_in.cts_n};
    end
  end
  assign mdm_out.rts_n = !(HAS_RC && mc_reg[MC_RTS] && !loop);
  assign mdm_out.dtr_n = !(HAS_FULL && mc_reg[MC_DTR] && !loop);
  assign ir_mode = ir_reg;

  // ring delta on pin low-to-high, which is the active-high ri falling
  always_comb begin
    delta_next = delta_reg;
    if (rd_ms) begin
      delta_next = 4'h0;
    end
    delta_next[0] = delta_next[0] | (mst[0] ^ mst_prev_reg[0]);
    delta_next[1] = delta_next[1] | (mst[1] ^ mst_prev_reg[1]);
    delta_next[2] = delta_next[2] | (mst_prev_reg[2] & ~mst[2]);
    delta_next[3] = delta_next[3] | (mst[3] ^ mst_prev_reg[3]);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mst_prev_reg <= 4'h0;
      delta_reg <= 4'h0;
    end else begin
      mst_prev_reg <= mst;
      delta_reg <= delta_next;
    end
  end

  assign tx_load = (tx_st_reg == ST_IDLE) && !thr_empty_reg;
  assign stop_last = !lc_reg[LC_STB] ? STOP1_LAST : (lc_reg[1:0] == 2'h0 ? STOP15_LAST : STOP2_LAST);
  assign tx_tick_end = (tx_st_reg == ST_STOP) ? (tx_cnt_reg == stop_last) : (tx_cnt_reg[3:0] == CNT_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thr_reg <= 8'h00;
      thr_empty_reg <= 1'h1;
    end else begin
      if (tx_load) begin
        thr_empty_reg <= 1'h1;
      end
      if (wr_data) begin
        thr_reg <= wdata;
        thr_empty_reg <= 1'h0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thre_pend_reg <= 1'h0;
    end else if (tx_load || (wr_ie && wdata[IE_TH] && thr_empty_reg)) begin
      thre_pend_reg <= 1'h1;
    end else if (wr_data || (rd_iid && iid == IID_TH)) begin
      thre_pend_reg <= 1'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st_reg <= ST_IDLE;
      tx_ser_reg <= 1'h1;
      tx_cnt_reg <= 5'h00;
      tx_bit_reg <= 3'h0;
      tsr_reg <= 8'h00;
      tx_par_reg <= 1'h0;
    end else if (tx_load) begin
      tx_st_reg <= ST_START;
      tx_ser_reg <= 1'h0;
      tx_cnt_reg <= 5'h00;
      tsr_reg <= thr_reg & dmask;
      tx_par_reg <= lc_reg[LC_STICK] ? !lc_reg[LC_EPS] : (^(thr_reg & dmask)) ^ !lc_reg[LC_EPS];
    end else if (btick && tx_st_reg != ST_IDLE) begin
      tx_cnt_reg <= tx_cnt_reg + 5'h01;
      if (tx_tick_end) begin
        tx_cnt_reg <= 5'h00;
        case (tx_st_reg)
          ST_START: begin
            tx_st_reg <= ST_DATA;
            tx_ser_reg <= tsr_reg[0];
            tx_bit_reg <= 3'h0;
          end
          ST_DATA: begin
            tsr_reg <= tsr_reg >> 1;
            tx_bit_reg <= tx_bit_reg + 3'h1;
            if (tx_bit_reg != last_bit) begin
              tx_ser_reg <= tsr_reg[1];
            end else if (lc_reg[LC_PEN]) begin
              tx_st_reg <= ST_PAR;
              tx_ser_reg <= tx_par_reg;
            end else begin
              tx_st_reg <= ST_STOP;
              tx_ser_reg <= 1'h1;
            end
          end
          ST_PAR: begin
            tx_st_reg <= ST_STOP;
            tx_ser_reg <= 1'h1;
          end
          default: begin
            tx_st_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd_reg <= 1'h1;
    end else begin
      txd_reg <= loop || (tx_ser_reg && !lc_reg[LC_BRK]);
    end
  end
  assign txd = txd_reg;

  // break forces the looped line low too, so loop-back can test detection
  assign rx_in = loop ? (tx_ser_reg && !lc_reg[LC_BRK]) : rxd;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_filt_reg <= 1'h1;
      filt_cnt_reg <= 2'h0;
    end else if (btick) begin
      if (rx_in == rx_filt_reg) begin
        filt_cnt_reg <= 2'h0;
      end else if (filt_cnt_reg == FILT_LAST) begin
        rx_filt_reg <= rx_in;
        filt_cnt_reg <= 2'h0;
      end else begin
        filt_cnt_reg <= filt_cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_reg <= ST_IDLE;
      rx_cnt_reg <= 4'h0;
      rx_bit_reg <= 3'h0;
      rsr_reg <= 8'h00;
      rx_par_reg <= 1'h0;
    end else if (btick) begin
      rx_cnt_reg <= rx_cnt_reg + 4'h1;
      case (rx_st_reg)
        ST_IDLE: begin
          rx_cnt_reg <= 4'h0;
          if (!rx_filt_reg) begin
            rx_st_reg <= ST_START;
          end
        end
        ST_START: begin
          if (rx_cnt_reg == CNT_MID) begin
            rx_cnt_reg <= 4'h0;
            rsr_reg <= 8'h00;
            rx_bit_reg <= 3'h0;
            rx_st_reg <= rx_filt_reg ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (rx_cnt_reg == CNT_LAST) begin
            rsr_reg[rx_bit_reg] <= rx_filt_reg;
            rx_bit_reg <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == last_bit) begin
              rx_st_reg <= lc_reg[LC_PEN] ? ST_PAR : ST_STOP;
            end
          end
        end
        ST_PAR: begin
          if (rx_cnt_reg == CNT_LAST) begin
            rx_par_reg <= rx_filt_reg;
            rx_st_reg <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (rx_cnt_reg == CNT_LAST) begin
            rx_st_reg <= rx_filt_reg ? ST_IDLE : ST_BRK;
          end
        end
        default: begin
          if (rx_filt_reg) begin
            rx_st_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign rx_fin = btick && rx_st_reg == ST_STOP && rx_cnt_reg == CNT_LAST;
  assign rx_pe = lc_reg[LC_PEN] &&
    (rx_par_reg != (lc_reg[LC_STICK] ? !lc_reg[LC_EPS] : (^rsr_reg) ^ !lc_reg[LC_EPS]));
  assign rx_fe = !rx_filt_reg;
  assign rx_bi = rx_fe && rsr_reg == 8'h00 && !(lc_reg[LC_PEN] && rx_par_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rbr_reg <= 8'h00;
    end else if (rx_fin) begin
      rbr_reg <= rsr_reg;
    end
  end

  // ls_reg: 0 ready, 1 overrun, 2 parity, 3 framing, 4 break; set beats clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ls_reg <= 5'h00;
    end else begin
      ls_reg[0] <= rx_fin || (ls_reg[0] && !rd_data);
      ls_reg[1] <= (rx_fin && ls_reg[0] && !rd_data) || (ls_reg[1] && !rd_ls);
      ls_reg[2] <= (rx_fin && rx_pe) || (ls_reg[2] && !rd_ls);
      ls_reg[3] <= (rx_fin && rx_fe) || (ls_reg[3] && !rd_ls);
      ls_reg[4] <= (rx_fin && rx_bi) || (ls_reg[4] && !rd_ls);
    end
  end

  always_comb begin
    if (ie_reg[IE_LS] && |ls_reg[4:1]) begin
      iid = IID_LS;
    end else if (ie_reg[IE_RD] && ls_reg[0]) begin
      iid = IID_RD;
    end else if (ie_reg[IE_TH] && thre_pend_reg) begin
      iid = IID_TH;
    end else if (ie_reg[IE_MS] && |delta_reg) begin
      iid = IID_MS;
    end else begin
      iid = IID_NONE;
    end
  end
  assign irq = (iid != IID_NONE);

  always_comb begin
    hit = 1'h1;
    if (addr == OFF_DATA) begin
      rdata = divisor_access_select ? dll_reg : rbr_reg;
    end else if (addr == OFF_IE) begin
      rdata = divisor_access_select ? dlm_reg : ie_reg;
    end else if (addr == OFF_IID) begin
      rdata = iid;
    end else if (addr == OFF_LC) begin
      rdata = lc_reg;
    end else if (addr == OFF_MC) begin
      rdata = mc_reg;
    end else if (addr == OFF_LS) begin
      rdata = {1'h0, thr_empty_reg && tx_st_reg == ST_IDLE, thr_empty_reg, ls_reg};
    end else if (addr == OFF_MS) begin
      rdata = {mst, delta_reg};
    end else if (addr == OFF_SCR) begin
      rdata = scr_reg;
    end else if (addr == OFF_IRC) begin
      rdata = {7'h00, ir_reg};
    end else begin
      rdata = 8'h00;
      hit = 1'h0;
    end
  end
endmodule
